// ---- inc/port_regs.svh ----
// Constants for the eight-bit port: offsets, fields, reset values, timer codes.
// Assumes a 16-bit register address and an eight-bit data path.
// Summary of operation
// - Modes 1-3 and 7: direction bit 1 drives the pin, 0 makes it input.
// - Modes 4-6: pins 3-0 drive upper address when direction bit is 1.
// - Modes 4-6: pins 7-4 are general outputs when direction bit is 1.
// - Direction register is write-only; reads return a fixed meaningless value.
// - Direction clears on power-on and hardware standby, kept otherwise.
// - Manual reset resets the timer unit; pins then follow direction and data.
// - Software standby: address pins hold or float per standby keep bit.
// - Output data register is eight-bit read/write, the pin data source unless address or timer drives the pin.
// - Output data clears on power-on and hardware standby, kept otherwise.
// - Pin-state register is read-only; writes to it do nothing.
// - Pin-state read gives data bit when direction is 1, pin level otherwise.
// - Pin-state follows pins after power-on; held through manual reset, software standby, except during hardware standby.
// - Pin 7 carries channel 2 B compare output in normal mode, codes 1-3, 5-7.
// - Pin 7 carries PWM mode 2 output when B field not xx00, clear not 010.
`ifndef PORT_REGS_SVH
`define PORT_REGS_SVH
`define OFS_PORT_DIRECTION 16'hfeb0
`define OFS_PORT_PIN_LEVELS 16'hff50
`define OFS_PORT_OUTPUT_DATA 16'hff60
`define OFS_STANDBY_CONTROL 16'hff70
`define RST_PORT_DIRECTION 8'h00
`define RST_PORT_OUTPUT_DATA 8'h00
`define RST_STANDBY_CONTROL 8'h00
`define DIRECTION_READ_VALUE 8'h00
`define UNMAPPED_READ_VALUE 8'h00
`define BIT_STANDBY_OUTPUT_KEEP 0
`define TIMER_PIN_INDEX 7
`define TMODE_NORMAL 4'h0
`define TMODE_PWM2 4'h3
`define CCLR_PWM2_BLOCK 3'h2
`endif

// ---- inc/port_pkg.sv ----
// Types for the eight-bit port: operating modes and signal bundles.
// Assumes nothing beyond a SystemVerilog compiler.
package port_pkg;
	typedef enum logic [2:0]
	{
		OPMODE_0 = 3'h0,
		OPMODE_1 = 3'h1,
		OPMODE_2 = 3'h2,
		OPMODE_3 = 3'h3,
		OPMODE_4 = 3'h4,
		OPMODE_5 = 3'h5,
		OPMODE_6 = 3'h6,
		OPMODE_7 = 3'h7
	} op_mode_e;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed
	{
		logic [3:0] timer_mode_field;
		logic [3:0] b_io_select;
		logic [2:0] counter_clear_select;
		logic compare_out;
		logic pwm2_out;
	} chan2_ctl_s;
endpackage

// ---- verilog/eight_bit_port_with_timer_pins.sv ----
// Eight-bit I/O port with upper address outputs and a shared timer pin.
// Assumes a synchronous register master and pins sampled on clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "port_regs.svh"
module eight_bit_port_with_timer_pins
	import port_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int ADDR_PINS = 4
)
(
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire bus_req_s bus,
	output logic [7:0] rdata_q,
	// Chip state
	input wire op_mode_e op_mode,
	input wire logic manual_reset,
	input wire logic hw_standby,
	input wire logic sw_standby,
	// Address bus controller
	input wire logic [ADDR_PINS-1:0] upper_address,
	// Timer pulse unit
	input wire chan2_ctl_s chan2,
	output logic timer_pulse_unit_reset_q,
	output logic ext_timer_clock_d_q,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out_q,
	output logic [WIDTH-1:0] pin_oe_q
);

	// The register map and the timer pin index only fit the eight-bit layout
	if (WIDTH != 8)
	begin : g_bad_width
		$error("port width must be 8");
	end
	if (ADDR_PINS < 1 || ADDR_PINS > WIDTH)
	begin : g_bad_addr
		$error("address pin count out of range");
	end

	logic [WIDTH-1:0] port_direction_q;
	logic [WIDTH-1:0] port_output_data_q;
	logic [WIDTH-1:0] pin_levels_q;
	logic [7:0] standby_control_q;
	logic [WIDTH-1:0] pin_out_d;
	logic [WIDTH-1:0] pin_oe_d;
	logic [WIDTH-1:0] pin_state_view;
	logic [7:0] rdata_d;
	logic ext_mode;
	logic compare_sel;
	logic pwm2_sel;
	logic timer_owns_pin;
	logic hold_levels;
	logic standby_output_keep;
	logic [WIDTH-1:0] address_wide;

	assign standby_output_keep = standby_control_q[`BIT_STANDBY_OUTPUT_KEEP];
	assign hold_levels = manual_reset | sw_standby;
	// Padded so the per-pin loop never indexes past the address bus
	assign address_wide = WIDTH'(upper_address);

	// Operating mode decode
	always_comb
	begin
		case (op_mode)
			OPMODE_4, OPMODE_5, OPMODE_6:
				ext_mode = 1'b1;
			default:
				ext_mode = 1'b0;
		endcase
	end

	// Timer output selection for pin 7
	always_comb
	begin
		compare_sel = 1'b0;
		if (chan2.timer_mode_field == `TMODE_NORMAL)
		begin
			case (chan2.b_io_select)
				4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7:
					compare_sel = 1'b1;
				default:
					compare_sel = 1'b0;
			endcase
		end
	end

	assign pwm2_sel = (chan2.timer_mode_field == `TMODE_PWM2)
		&& (chan2.b_io_select[1:0] != 2'h0)
		&& (chan2.counter_clear_select != `CCLR_PWM2_BLOCK);

	// Timer is held in reset during manual reset, so it cannot claim the pin
	assign timer_owns_pin = (compare_sel | pwm2_sel) & ~manual_reset;

	// Direction register: write-only, cleared by power-on and hardware standby
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			port_direction_q <= `RST_PORT_DIRECTION;
		else if (hw_standby)
			port_direction_q <= `RST_PORT_DIRECTION;
		else if (bus.wr && bus.addr == `OFS_PORT_DIRECTION)
			port_direction_q <= bus.wdata[WIDTH-1:0];
	end

	// Output data register, kept through manual reset and software standby
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			port_output_data_q <= `RST_PORT_OUTPUT_DATA;
		else if (hw_standby)
			port_output_data_q <= `RST_PORT_OUTPUT_DATA;
		else if (bus.wr && bus.addr == `OFS_PORT_OUTPUT_DATA)
			port_output_data_q <= bus.wdata[WIDTH-1:0];
	end

	// Standby control keep bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			standby_control_q <= `RST_STANDBY_CONTROL;
		else if (bus.wr && bus.addr == `OFS_STANDBY_CONTROL)
			standby_control_q <= bus.wdata;
	end

	// Pin-level snapshot; frozen while manual reset or software standby, unless hardware standby is also active
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_levels_q <= '0;
		else if (hw_standby || !hold_levels)
			pin_levels_q <= pin_in;
	end

	// Per-pin drive selection
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_pin
			logic addr_pin;
			assign addr_pin = ext_mode && (i < ADDR_PINS);
			always_comb
			begin
				pin_out_d[i] = port_output_data_q[i];
				pin_oe_d[i] = port_direction_q[i];
				if (addr_pin)
				begin
					pin_out_d[i] = address_wide[i];
					if (sw_standby)
					begin
						// Standby freezes the last driven level instead of the live bus; the keep bit only gates the enable
						pin_out_d[i] = pin_out_q[i];
						pin_oe_d[i] = standby_output_keep & pin_oe_q[i];
					end
				end
				if (i == `TIMER_PIN_INDEX && timer_owns_pin)
				begin
					pin_oe_d[i] = 1'b1;
					pin_out_d[i] = compare_sel ? chan2.compare_out : chan2.pwm2_out;
				end
				if (hw_standby)
					pin_oe_d[i] = 1'b0;
				pin_state_view[i] = port_direction_q[i] ?
					port_output_data_q[i] : pin_levels_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
		end
		else
		begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// Timer still sees pin 7 whether or not it drives it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ext_timer_clock_d_q <= 1'b0;
		else
			ext_timer_clock_d_q <= pin_in[`TIMER_PIN_INDEX];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_pulse_unit_reset_q <= 1'b0;
		else
			timer_pulse_unit_reset_q <= manual_reset;
	end

	// Read mux; writes to the pin-state offset fall through with no effect
	always_comb
	begin
		case (bus.addr)
			`OFS_PORT_DIRECTION:
				rdata_d = `DIRECTION_READ_VALUE;
			`OFS_PORT_OUTPUT_DATA:
				rdata_d = port_output_data_q;
			`OFS_PORT_PIN_LEVELS:
				rdata_d = pin_state_view;
			`OFS_STANDBY_CONTROL:
				rdata_d = standby_control_q;
			default:
				rdata_d = `UNMAPPED_READ_VALUE;
		endcase
	end

	// Read data stands one cycle only, zero otherwise
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= '0;
		else if (bus.rd)
			rdata_q <= rdata_d;
		else
			rdata_q <= '0;
	end

	// Checks

	direction_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!ext_mode && !timer_owns_pin && !hw_standby)
		|=> pin_oe_q == $past(port_direction_q))
		else $error("pin enables do not follow direction");

	address_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ext_mode && !sw_standby && !hw_standby && port_direction_q[0])
		|=> pin_oe_q[0] && pin_out_q[0] == $past(upper_address[0]))
		else $error("address pin 0 not driven");

	upper_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ext_mode && !hw_standby && port_direction_q[4])
		|=> pin_oe_q[4] && pin_out_q[4] == $past(port_output_data_q[4]))
		else $error("pin 4 data not driven");

	direction_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		(bus.rd && bus.addr == `OFS_PORT_DIRECTION) |=> rdata_q == `DIRECTION_READ_VALUE)
		else $error("direction register leaked on read");

	standby_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		hw_standby |=> port_direction_q == '0 && port_output_data_q == '0)
		else $error("standby did not clear registers");

	manual_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(manual_reset && !hw_standby && !bus.wr) |=> $stable(port_output_data_q)
		&& $stable(port_direction_q))
		else $error("manual reset changed port registers");

	standby_float_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sw_standby && ext_mode && !standby_output_keep) |=> pin_oe_q[0] == 1'b0)
		else $error("address pin drives in standby");

	pin_state_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		(bus.rd && bus.addr == `OFS_PORT_PIN_LEVELS && port_direction_q[1])
		|=> rdata_q[1] == $past(port_output_data_q[1]))
		else $error("pin-state read ignored data register");

	levels_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sw_standby && !hw_standby) |=> $stable(pin_levels_q))
		else $error("pin levels changed in standby");

	compare_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		(compare_sel && !manual_reset && !hw_standby)
		|=> pin_oe_q[7] && pin_out_q[7] == $past(chan2.compare_out))
		else $error("pin 7 missing compare output");

	timer_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		manual_reset |=> timer_pulse_unit_reset_q)
		else $error("timer not reset by manual reset");

	timer_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(manual_reset && !hw_standby && !ext_mode)
		|=> pin_oe_q[7] == $past(port_direction_q[7])
		&& pin_out_q[7] == $past(port_output_data_q[7]))
		else $error("timer drove pin 7 in manual reset");

	pwm_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pwm2_sel && !manual_reset && !hw_standby)
		|=> pin_oe_q[7] && pin_out_q[7] == $past(chan2.pwm2_out))
		else $error("pin 7 missing pwm output");

	read_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		!bus.rd |=> rdata_q == '0)
		else $error("read data stood too long");

	pin_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(bus.wr && bus.addr == `OFS_PORT_PIN_LEVELS && !hw_standby)
		|=> $stable(port_output_data_q) && $stable(port_direction_q))
		else $error("pin-state write changed a register");

	timer_input_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> ext_timer_clock_d_q == $past(pin_in[`TIMER_PIN_INDEX]))
		else $error("timer input does not follow pin 7");

endmodule
`default_nettype wire

// ---- verif/pin_partner.sv ----
// Far side model: outside pin drive and timer channel 2 waveform levels.
// Assumes the bench supplies the outside drive and the waveform level.
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
	// Port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Outside world
	input wire logic [7:0] ext,
	input wire logic wave,
	// Back to the port
	output logic [7:0] pin_in,
	output logic compare_out,
	output logic pwm2_out
);
	// Driven bits read back the port's own level, released bits the outside level
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
	// Opposite levels so a swapped timer source shows at pin 7
	assign compare_out = wave;
	assign pwm2_out = ~wave;
endmodule
`default_nettype wire

// ---- verif/eight_bit_port_with_timer_pins_tb.sv ----
// Self-checking bench for the eight-bit port with timer pin.
// Assumes the register offsets and codes of port_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "port_regs.svh"
module eight_bit_port_with_timer_pins_tb
	import port_pkg::*;
;
	typedef struct packed {logic [2:0] m; logic [7:0] dir, dat, ext, rd;} row_s;
	row_s rows[8] = '{'{3'h0, 8'hff, 8'ha5, 8'h00, 8'ha5}, '{3'h1, 8'h0f, 8'h3c, 8'ha0, 8'hac},
		'{3'h2, 8'hf0, 8'h3c, 8'h5a, 8'h3a}, '{3'h3, 8'h00, 8'hff, 8'h96, 8'h96},
		'{3'h4, 8'h0f, 8'h12, 8'hc0, 8'hc2}, '{3'h5, 8'hff, 8'h81, 8'h00, 8'h81},
		'{3'h6, 8'h3c, 8'h55, 8'h81, 8'h95}, '{3'h7, 8'h80, 8'h80, 8'h7f, 8'hff}};
	row_s r;
	logic clk = 0;
	logic rst_n = 0;
	bus_req_s bus = '0;
	op_mode_e mode = OPMODE_1;
	logic man_rst = 0, hw_sb = 0, sw_sb = 0, wave = 1;
	logic [3:0] ua = 4'h5, tmf = 4'h0, bio = 4'h0;
	logic [2:0] ccs = 3'h0;
	logic [7:0] ext = 8'h00, rdata, pout, poe, pin;
	logic cmp, pwm, tpu_rst, tclk;
	int bad_count = 0, checks_done = 0, cycles = 0;
	chan2_ctl_s ch2;
	assign ch2 = {tmf, bio, ccs, cmp, pwm};
	always #20 clk = ~clk;
	eight_bit_port_with_timer_pins u_eight_bit_port_with_timer_pins (.clk(clk), .rst_n(rst_n),
		.bus(bus), .rdata_q(rdata), .op_mode(mode), .manual_reset(man_rst), .hw_standby(hw_sb),
		.sw_standby(sw_sb), .upper_address(ua), .chan2(ch2), .timer_pulse_unit_reset_q(tpu_rst),
		.ext_timer_clock_d_q(tclk), .pin_in(pin), .pin_out_q(pout), .pin_oe_q(poe));
	pin_partner u_pin_partner (.pin_out(pout), .pin_oe(poe), .ext(ext), .wave(wave),
		.pin_in(pin), .compare_out(cmp), .pwm2_out(pwm));
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		chk(name, rdata, exp);
	endtask
	// Waits two edges so the registered pins follow the new controls
	task automatic t7(input logic [3:0] m, b, input logic [2:0] c, input logic own, lv);
		@(posedge clk);
		tmf <= m;
		bio <= b;
		ccs <= c;
		repeat (2) @(negedge clk);
		chk("pin7_oe", {7'h0, poe[7]}, {7'h0, own});
		chk("pin7_out", {7'h0, pout[7] & own}, {7'h0, own & lv});
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			end_sim();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			r = rows[i];
			@(posedge clk);
			mode <= op_mode_e'(r.m);
			ext <= r.ext;
			wr(`OFS_PORT_DIRECTION, r.dir);
			wr(`OFS_PORT_OUTPUT_DATA, r.dat);
			repeat (2) @(negedge clk);
			chk("pin_oe", poe, r.dir);
			chk("pin_out", pout & poe, (r.m inside {[4:6]} ? {r.dat[7:4], ua} : r.dat) & r.dir);
			rd(`OFS_PORT_PIN_LEVELS, r.rd, "pin_levels");
			chk("tclk", {7'h0, tclk}, {7'h0, r.dir[7] ? r.dat[7] : r.ext[7]});
		end
		@(posedge clk);
		mode <= OPMODE_1;
		rd(`OFS_PORT_DIRECTION, `DIRECTION_READ_VALUE, "dir_read");
		rd(16'h1234, `UNMAPPED_READ_VALUE, "unmapped");
		wr(`OFS_PORT_OUTPUT_DATA, 8'h5a);
		wr(`OFS_PORT_DIRECTION, 8'h0f);
		wr(`OFS_PORT_PIN_LEVELS, 8'h00);
		ext <= 8'hc0;
		rd(`OFS_PORT_OUTPUT_DATA, 8'h5a, "out_data");
		// Timer owns pin 7 here, but manual reset must hold it back
		@(posedge clk);
		man_rst <= 1'b1;
		tmf <= `TMODE_NORMAL;
		bio <= 4'h1;
		ext <= 8'h30;
		repeat (2) @(negedge clk);
		chk("tpu_rst", {7'h0, tpu_rst}, 8'h01);
		chk("mr_oe", poe, 8'h0f);
		chk("mr_out", pout & poe, 8'h0a);
		rd(`OFS_PORT_PIN_LEVELS, 8'hca, "mr_levels");
		@(posedge clk);
		man_rst <= 1'b0;
		for (int i = 0; i < 16; i++)
			t7(`TMODE_NORMAL, i[3:0], 3'h0, i inside {[1:3], [5:7]}, 1'b1);
		t7(`TMODE_PWM2, 4'h1, 3'h0, 1'b1, 1'b0);
		t7(`TMODE_PWM2, 4'h4, 3'h0, 1'b0, 1'b0);
		t7(`TMODE_PWM2, 4'h1, `CCLR_PWM2_BLOCK, 1'b0, 1'b0);
		chk("tpu_rst_off", {7'h0, tpu_rst}, 8'h00);
		@(posedge clk);
		mode <= OPMODE_4;
		wr(`OFS_STANDBY_CONTROL, 8'h01 << `BIT_STANDBY_OUTPUT_KEEP);
		sw_sb <= 1'b1;
		ua <= 4'ha;
		repeat (2) @(negedge clk);
		chk("keep_out", pout & poe & 8'h0f, 8'h05);
		@(posedge clk);
		sw_sb <= 1'b0;
		wr(`OFS_STANDBY_CONTROL, 8'h00);
		sw_sb <= 1'b1;
		repeat (2) @(negedge clk);
		chk("float_oe", poe & 8'h0f, 8'h00);
		@(posedge clk);
		sw_sb <= 1'b0;
		repeat (2) @(negedge clk);
		chk("sw_dir", poe, 8'h0f);
		@(posedge clk);
		hw_sb <= 1'b1;
		repeat (2) @(negedge clk);
		chk("hw_oe", poe, 8'h00);
		@(posedge clk);
		hw_sb <= 1'b0;
		rd(`OFS_PORT_OUTPUT_DATA, 8'h00, "hw_data");
		wr(`OFS_PORT_OUTPUT_DATA, 8'h33);
		wr(`OFS_PORT_DIRECTION, 8'hff);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(`OFS_PORT_OUTPUT_DATA, 8'h00, "por_data");
		chk("por_oe", poe, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
